/* pin_mux_pkg.sv */
// Constants shared by the port B data pin multiplexer.
package pin_mux_pkg;
  // ****************************************
  // Function selection codes
  // ****************************************
  localparam logic [1:0] FSEL_GPIO = 2'h0;
  localparam logic [1:0] FSEL_SERIAL = 2'h1;
  localparam logic [1:0] FSEL_TIMER = 2'h2;
  localparam logic [1:0] FSEL_PWM_SRC = 2'h3;
  // ****************************************
  // Serial word layout
  // ****************************************
  localparam int WORD_W = 8;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [7:0] IDLE_WORD = 8'hff;
  // ****************************************
  // Transmit buffer shape
  // ****************************************
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_COUNT_FULL = 2'h2;
  localparam logic [1:0] BUF_COUNT_ONE = 2'h1;
  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [1:0] RST_FSEL = FSEL_GPIO;
  localparam logic [1:0] RST_PULLUP = 2'h3;
  localparam logic [1:0] RST_OE = 2'h0;
  localparam logic [1:0] RST_PAIR = 2'h0;
  localparam logic [1:0] RST_COUNT = 2'h0;
  localparam logic [7:0] RST_WORD = 8'h00;
  localparam logic [2:0] RST_BITS = 3'h0;
endpackage : pin_mux_pkg

/* port_b_spi_data_pin_mux.sv */
// Function multiplexer and serial data path for port B pins two and three.
//
// Function
// - In general purpose mode each pin is an input or output under software.
// - After reset both pins come up in their general purpose function.
// - Only the integration unit selection inputs route a peripheral onto a pin.
// - Pin two is input as master, driven output as slave.
// - An unselected slave releases pin two to high impedance.
// - Slave puts each bit on pin two half a clock before sampling edge.
// - Pin three is driven output as master, input as slave.
// - Master puts each bit on pin three half a clock before sampling edge.
// - Pin two in source function feeds the pwm pair four and five.
// - Pin three in source function feeds the pwm pair two and three.
// - Pin two offers timer A channel two, bidirectional.
// - Pin three offers timer A channel three, bidirectional.
`timescale 1ns/100ps
module port_b_spi_data_pin_mux
  import pin_mux_pkg::*;
(
  // Clocks and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ser_clk,
  // Frame level from the select logic, high while a word moves
  input wire logic link_frame,
  // Pins
  input wire logic port_b_pin_two_in,
  output logic port_b_pin_two_out,
  output logic port_b_pin_two_oe,
  output logic port_b_pin_two_pullup,
  input wire logic port_b_pin_three_in,
  output logic port_b_pin_three_out,
  output logic port_b_pin_three_oe,
  output logic port_b_pin_three_pullup,
  // System integration unit selection
  input wire logic [1:0] fsel_two,
  input wire logic [1:0] fsel_three,
  input wire logic serial_master,
  // General purpose port, bit 0 is pin two
  input wire logic [1:0] gpio_dir,
  input wire logic [1:0] gpio_out,
  output logic [1:0] gpio_in,
  // Timer A channels
  input wire logic timer_a_chan_two_out,
  input wire logic timer_a_chan_two_oe,
  output logic timer_a_chan_two_in,
  output logic timer_a_chan_two_here,
  input wire logic timer_a_chan_three_out,
  input wire logic timer_a_chan_three_oe,
  output logic timer_a_chan_three_in,
  output logic timer_a_chan_three_here,
  // External pwm sources
  output logic ext_pwm_source_zero,
  output logic ext_pwm_source_one,
  // Transmit stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Receive stream
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_overrun
);

  // ****************************************
  // Helpers
  // ****************************************
  // Returns {oe, out} for the non-serial functions of one pin.
  function automatic logic [1:0] pin_drive(input logic [1:0] fsel, input logic dir, input logic gout,
                                           input logic toe, input logic tout);
    logic [1:0] res;
    res = 2'h0;
    case (fsel)
      FSEL_GPIO: res = {dir, gout};
      FSEL_TIMER: res = {toe, tout};
      default: res = 2'h0;
    endcase
    return res;
  endfunction : pin_drive

  // ****************************************
  // Clock domain: pin sampling and selection
  // ****************************************
  logic [1:0] pin_meta_ff, pin_sync_ff;
  logic [1:0] fsel_two_ff, fsel_three_ff, nxt_fsel_two, nxt_fsel_three;
  logic master_ff, nxt_master;
  logic [1:0] drv_oe_ff, drv_out_ff, pullup_ff, nxt_drv_oe, nxt_drv_out, nxt_pullup;
  logic [1:0] gpio_in_ff, nxt_gpio_in, tin_ff, nxt_tin, here_ff, nxt_here, psrc_ff, nxt_psrc;
  logic [1:0] d_two, d_three;

  always_comb begin
    d_two = pin_drive(fsel_two_ff, gpio_dir[0], gpio_out[0], timer_a_chan_two_oe, timer_a_chan_two_out);
    d_three = pin_drive(fsel_three_ff, gpio_dir[1], gpio_out[1], timer_a_chan_three_oe, timer_a_chan_three_out);
    nxt_fsel_two = fsel_two;
    nxt_fsel_three = fsel_three;
    nxt_master = serial_master;
    nxt_drv_oe = {d_three[1], d_two[1]};
    nxt_drv_out = {d_three[0], d_two[0]};
    nxt_pullup[0] = (fsel_two_ff == FSEL_GPIO) && !gpio_dir[0];
    nxt_pullup[1] = (fsel_three_ff == FSEL_GPIO) && !gpio_dir[1];
    nxt_gpio_in = pin_sync_ff;
    nxt_tin[0] = (fsel_two_ff == FSEL_TIMER) && pin_sync_ff[0];
    nxt_tin[1] = (fsel_three_ff == FSEL_TIMER) && pin_sync_ff[1];
    nxt_here = {fsel_three_ff == FSEL_TIMER, fsel_two_ff == FSEL_TIMER};
    nxt_psrc[0] = (fsel_two_ff == FSEL_PWM_SRC) && pin_sync_ff[0];
    nxt_psrc[1] = (fsel_three_ff == FSEL_PWM_SRC) && pin_sync_ff[1];
    if (reset) begin
      nxt_fsel_two = RST_FSEL;
      nxt_fsel_three = RST_FSEL;
      nxt_master = 1'b0;
      nxt_drv_oe = RST_OE;
      nxt_drv_out = RST_PAIR;
      nxt_pullup = RST_PULLUP;
      nxt_gpio_in = RST_PAIR;
      nxt_tin = RST_PAIR;
      nxt_here = RST_PAIR;
      nxt_psrc = RST_PAIR;
    end
  end

  always_ff @(posedge clk) begin
    pin_meta_ff <= {port_b_pin_three_in, port_b_pin_two_in};
    pin_sync_ff <= pin_meta_ff;
    fsel_two_ff <= nxt_fsel_two;
    fsel_three_ff <= nxt_fsel_three;
    master_ff <= nxt_master;
    drv_oe_ff <= nxt_drv_oe;
    drv_out_ff <= nxt_drv_out;
    pullup_ff <= nxt_pullup;
    gpio_in_ff <= nxt_gpio_in;
    tin_ff <= nxt_tin;
    here_ff <= nxt_here;
    psrc_ff <= nxt_psrc;
  end

  // ****************************************
  // Clock domain: transmit buffer and hand-off
  // ****************************************
  // Two entries let software queue the next word while one waits for the link.
  logic [7:0] buf_mem_ff [BUF_DEPTH];
  logic [7:0] nxt_mem0, nxt_mem1;
  logic wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic [1:0] count_ff, nxt_count;
  logic [7:0] hold_ff, nxt_hold;
  logic req_tgl_ff, nxt_req_tgl;
  logic ack_meta_ff, ack_sync_ff;
  logic push, pop, ack_tgl_s, ready_ff, nxt_ready;

  always_comb begin
    push = tx_valid && (count_ff != BUF_COUNT_FULL);
    pop = (count_ff != RST_COUNT) && (req_tgl_ff == ack_sync_ff);
    nxt_mem0 = buf_mem_ff[0];
    nxt_mem1 = buf_mem_ff[1];
    if (push && !wr_ptr_ff) nxt_mem0 = tx_data;
    if (push && wr_ptr_ff) nxt_mem1 = tx_data;
    nxt_wr_ptr = wr_ptr_ff ^ push;
    nxt_rd_ptr = rd_ptr_ff ^ pop;
    nxt_count = count_ff;
    if (push && !pop) nxt_count = count_ff + BUF_COUNT_ONE;
    if (pop && !push) nxt_count = count_ff - BUF_COUNT_ONE;
    nxt_hold = pop ? buf_mem_ff[rd_ptr_ff] : hold_ff;
    nxt_req_tgl = req_tgl_ff ^ pop;
    if (reset) begin
      nxt_wr_ptr = 1'b0;
      nxt_rd_ptr = 1'b0;
      nxt_count = RST_COUNT;
      nxt_hold = RST_WORD;
      nxt_req_tgl = 1'b0;
    end
    nxt_ready = nxt_count != BUF_COUNT_FULL;
  end

  always_ff @(posedge clk) begin
    buf_mem_ff[0] <= nxt_mem0;
    buf_mem_ff[1] <= nxt_mem1;
    wr_ptr_ff <= nxt_wr_ptr;
    rd_ptr_ff <= nxt_rd_ptr;
    count_ff <= nxt_count;
    hold_ff <= nxt_hold;
    req_tgl_ff <= nxt_req_tgl;
    ready_ff <= nxt_ready;
    ack_meta_ff <= ack_tgl_s;
    ack_sync_ff <= ack_meta_ff;
  end

  // ****************************************
  // Clock domain: receive hand-off
  // ****************************************
  logic rx_meta_ff, rx_sync_ff, rx_seen_ff, nxt_rx_seen, rx_tgl_s;
  logic [7:0] rx_data_ff, nxt_rx_data, rx_word_s;
  logic rx_valid_ff, nxt_rx_valid, overrun_ff, nxt_overrun, rx_new;

  always_comb begin
    rx_new = rx_sync_ff != rx_seen_ff;
    nxt_rx_seen = rx_sync_ff;
    nxt_rx_data = rx_new ? rx_word_s : rx_data_ff;
    nxt_rx_valid = rx_valid_ff && !rx_ready;
    if (rx_new) nxt_rx_valid = 1'b1;
    nxt_overrun = overrun_ff || (rx_new && rx_valid_ff && !rx_ready);
    if (reset) begin
      nxt_rx_seen = 1'b0;
      nxt_rx_data = RST_WORD;
      nxt_rx_valid = 1'b0;
      nxt_overrun = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    rx_meta_ff <= rx_tgl_s;
    rx_sync_ff <= rx_meta_ff;
    rx_seen_ff <= nxt_rx_seen;
    rx_data_ff <= nxt_rx_data;
    rx_valid_ff <= nxt_rx_valid;
    overrun_ff <= nxt_overrun;
  end

  // ****************************************
  // Link domain: reset, mode and request crossing
  // ****************************************
  logic srst_meta_s, srst_s, mode_meta_s, mode_s, req_meta_s, req_sync_s;

  always_ff @(negedge ser_clk) begin
    srst_meta_s <= reset;
    srst_s <= srst_meta_s;
    mode_meta_s <= master_ff;
    mode_s <= mode_meta_s;
    req_meta_s <= req_tgl_ff;
    req_sync_s <= req_meta_s;
  end

  // ****************************************
  // Link domain: launch on the falling edge
  // ****************************************
  // The serial clock idles high, so the first edge of a frame launches the first bit.
  logic [2:0] bits_s, nxt_bits_s;
  logic [7:0] tx_shift_s, nxt_tx_shift_s, word_s;
  logic out_bit_s, nxt_out_bit_s, nxt_ack_tgl_s, take_s;

  always_comb begin
    take_s = (bits_s == BIT_FIRST) && (req_sync_s != ack_tgl_s);
    word_s = take_s ? hold_ff : IDLE_WORD;
    nxt_ack_tgl_s = ack_tgl_s ^ take_s;
    if (bits_s == BIT_FIRST) begin
      nxt_out_bit_s = word_s[WORD_W-1];
      nxt_tx_shift_s = {word_s[WORD_W-2:0], 1'b0};
    end else begin
      nxt_out_bit_s = tx_shift_s[WORD_W-1];
      nxt_tx_shift_s = {tx_shift_s[WORD_W-2:0], 1'b0};
    end
    if (srst_s) begin
      nxt_ack_tgl_s = 1'b0;
      nxt_out_bit_s = 1'b1;
      nxt_tx_shift_s = IDLE_WORD;
    end
  end

  always_ff @(negedge ser_clk) begin
    ack_tgl_s <= nxt_ack_tgl_s;
    out_bit_s <= nxt_out_bit_s;
    tx_shift_s <= nxt_tx_shift_s;
  end

  // ****************************************
  // Link domain: sample on the rising edge
  // ****************************************
  // Serial data is timed to the link clock by the protocol, so it is sampled directly.
  logic [7:0] rx_shift_s, nxt_rx_shift_s, nxt_rx_word_s;
  logic nxt_rx_tgl_s, in_bit_s;

  always_comb begin
    in_bit_s = mode_s ? port_b_pin_two_in : port_b_pin_three_in;
    nxt_rx_shift_s = {rx_shift_s[WORD_W-2:0], in_bit_s};
    nxt_bits_s = bits_s + BIT_STEP;
  end

  // A frame that ends mid-word is dropped: the frame level clears the count even with the clock stopped.
  always_ff @(posedge ser_clk or negedge link_frame) begin
    if (!link_frame) begin
      bits_s <= RST_BITS;
      rx_shift_s <= RST_WORD;
    end else begin
      bits_s <= nxt_bits_s;
      rx_shift_s <= nxt_rx_shift_s;
    end
  end

  always_comb begin
    nxt_rx_word_s = rx_word_s;
    nxt_rx_tgl_s = rx_tgl_s;
    if (bits_s == BIT_LAST) begin
      nxt_rx_word_s = nxt_rx_shift_s;
      nxt_rx_tgl_s = !rx_tgl_s;
    end
    if (srst_s) begin
      nxt_rx_word_s = RST_WORD;
      nxt_rx_tgl_s = 1'b0;
    end
  end

  always_ff @(posedge ser_clk) begin
    rx_word_s <= nxt_rx_word_s;
    rx_tgl_s <= nxt_rx_tgl_s;
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // The serial data paths bypass the clock domain registers to keep the half period launch timing.
  always_comb begin
    port_b_pin_two_out = drv_out_ff[0];
    port_b_pin_two_oe = drv_oe_ff[0];
    port_b_pin_three_out = drv_out_ff[1];
    port_b_pin_three_oe = drv_oe_ff[1];
    if (fsel_two_ff == FSEL_SERIAL) begin
      port_b_pin_two_out = out_bit_s;
      port_b_pin_two_oe = !master_ff && link_frame;
    end
    if (fsel_three_ff == FSEL_SERIAL) begin
      port_b_pin_three_out = out_bit_s;
      port_b_pin_three_oe = master_ff;
    end
  end

  assign port_b_pin_two_pullup = pullup_ff[0];
  assign port_b_pin_three_pullup = pullup_ff[1];
  assign gpio_in = gpio_in_ff;
  assign timer_a_chan_two_in = tin_ff[0];
  assign timer_a_chan_three_in = tin_ff[1];
  assign timer_a_chan_two_here = here_ff[0];
  assign timer_a_chan_three_here = here_ff[1];
  assign ext_pwm_source_zero = psrc_ff[0];
  assign ext_pwm_source_one = psrc_ff[1];
  assign tx_ready = ready_ff;
  assign rx_data = rx_data_ff;
  assign rx_valid = rx_valid_ff;
  assign rx_overrun = overrun_ff;

endmodule : port_b_spi_data_pin_mux

/* port_b_spi_data_pin_mux_properties.sv */
// Concurrent checks on the port B data pin multiplexer.
`timescale 1ns/100ps
module port_b_spi_data_pin_mux_properties
  import pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Selection and frame
  input wire logic link_frame,
  input wire logic serial_master,
  input wire logic [1:0] fsel_two,
  input wire logic [1:0] fsel_three,
  input wire logic [1:0] gpio_dir,
  input wire logic [1:0] gpio_out,
  // Pins and peripheral sides
  input wire logic port_b_pin_two_in,
  input wire logic port_b_pin_two_out,
  input wire logic port_b_pin_two_oe,
  input wire logic port_b_pin_two_pullup,
  input wire logic port_b_pin_three_in,
  input wire logic port_b_pin_three_oe,
  input wire logic port_b_pin_three_pullup,
  input wire logic timer_a_chan_two_out,
  input wire logic timer_a_chan_two_oe,
  input wire logic timer_a_chan_two_here,
  input wire logic ext_pwm_source_zero,
  input wire logic ext_pwm_source_one
);
  // All checks sit in the system clock domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_sel2(logic [1:0] f, logic [1:0] c);
    (f == c)[*2];
  endsequence
  sequence s_src5(logic [1:0] f, logic p);
    (f == FSEL_PWM_SRC && $stable(p))[*5];
  endsequence
  sequence s_ser3(logic [1:0] f);
    (f == FSEL_SERIAL && $stable(serial_master))[*3];
  endsequence
  a_reset_pins_in:
    assert property (disable iff (1'b0) reset |=> !port_b_pin_two_oe && !port_b_pin_three_oe &&
      port_b_pin_two_pullup && port_b_pin_three_pullup) else $error("pin state wrong in reset");
  a_gpio_two_drive:
    assert property (s_sel2(fsel_two, FSEL_GPIO) |=> port_b_pin_two_oe == $past(gpio_dir[0]) &&
      (!$past(gpio_dir[0]) || port_b_pin_two_out == $past(gpio_out[0]))) else $error("gpio pin two wrong");
  a_gpio_three_dir:
    assert property (s_sel2(fsel_three, FSEL_GPIO) |=> port_b_pin_three_oe == $past(gpio_dir[1]) &&
      port_b_pin_three_pullup != $past(gpio_dir[1])) else $error("gpio pin three wrong");
  a_timer_two_route:
    assert property (s_sel2(fsel_two, FSEL_TIMER) |=> timer_a_chan_two_here &&
      port_b_pin_two_oe == $past(timer_a_chan_two_oe) &&
      (!port_b_pin_two_oe || port_b_pin_two_out == $past(timer_a_chan_two_out))) else $error("timer route wrong");
  a_source_zero_feed:
    assert property (s_src5(fsel_two, port_b_pin_two_in) |=> !port_b_pin_two_oe &&
      ext_pwm_source_zero == $past(port_b_pin_two_in)) else $error("source zero wrong");
  a_source_one_feed:
    assert property (s_src5(fsel_three, port_b_pin_three_in) |=> !port_b_pin_three_oe &&
      ext_pwm_source_one == $past(port_b_pin_three_in)) else $error("source one wrong");
  a_mosi_pin_dir:
    assert property (s_ser3(fsel_three) |=> port_b_pin_three_oe == $past(serial_master) &&
      !port_b_pin_three_pullup) else $error("pin three serial direction wrong");
  a_miso_pin_release:
    assert property (s_ser3(fsel_two) |=> port_b_pin_two_oe == (!$past(serial_master) && link_frame))
      else $error("pin two serial drive wrong");
endmodule : port_b_spi_data_pin_mux_properties
bind port_b_spi_data_pin_mux port_b_spi_data_pin_mux_properties u_props (.*);

/* ser_peer_model.sv */
// Serial peer at the far end of the data pins.
`timescale 1ns/100ps
module ser_peer_model (
  // Link clock and frame
  output logic ser_clk,
  output logic link_frame,
  // Data line toward the block and from it
  output logic sdo,
  output logic sdo_oe,
  input wire logic sdi
);
  initial begin
    ser_clk = 1'b1;
    link_frame = 1'b0;
    sdo = 1'b0;
    sdo_oe = 1'b0;
  end
  // Free clocking is only used while reset holds, so the link side sees its reset.
  task automatic spin(input int n);
    repeat (n) begin
      #15 ser_clk = 1'b0;
      #15 ser_clk = 1'b1;
    end
  endtask : spin
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    // The small lead keeps the link edges off the system clock edges.
    #3 link_frame = 1'b1;
    sdo_oe = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #15 ser_clk = 1'b0;
      sdo = tx[i];
      #15 ser_clk = 1'b1;
      rx[i] = sdi;
    end
    #15 link_frame = 1'b0;
    sdo_oe = 1'b0;
    sdo = ~sdo;
    #15;
  endtask : frame
endmodule : ser_peer_model

/* port_b_spi_data_pin_mux_tb.sv */
// Self-checking bench for the port B data pin multiplexer.
`timescale 1ns/100ps
module port_b_spi_data_pin_mux_tb
  import pin_mux_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic serial_master = 1'b1;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic [1:0] fsel_two = FSEL_GPIO;
  logic [1:0] fsel_three = FSEL_GPIO;
  logic [1:0] gpio_dir = 2'h0;
  logic [1:0] gpio_out = 2'h0;
  logic [1:0] bo = 2'h0;
  logic [1:0] bv = 2'h0;
  logic [1:0] toe = 2'h0;
  logic [1:0] tout = 2'h0;
  logic [7:0] w, rx_data;
  logic [1:0] gpio_in;
  logic port_b_pin_two_out, port_b_pin_two_oe, port_b_pin_two_pullup;
  logic port_b_pin_three_out, port_b_pin_three_oe, port_b_pin_three_pullup;
  logic timer_a_chan_two_in, timer_a_chan_two_here, timer_a_chan_three_in, timer_a_chan_three_here;
  logic ext_pwm_source_zero, ext_pwm_source_one, tx_ready, rx_valid, rx_overrun;
  logic ser_clk, link_frame, pe_do, pe_oe;
  wire timer_a_chan_two_oe = toe[0];
  wire timer_a_chan_three_oe = toe[1];
  wire timer_a_chan_two_out = tout[0];
  wire timer_a_chan_three_out = tout[1];
  // An undriven line without pull-up shows the inverse of the last drive so a stale level never passes.
  wire port_b_pin_two_in = port_b_pin_two_oe ? port_b_pin_two_out : bo[0] ? bv[0] :
    (pe_oe && serial_master) ? pe_do : port_b_pin_two_pullup ? 1'b1 : ~port_b_pin_two_out;
  wire port_b_pin_three_in = port_b_pin_three_oe ? port_b_pin_three_out : bo[1] ? bv[1] :
    (pe_oe && !serial_master) ? pe_do : port_b_pin_three_pullup ? 1'b1 : ~port_b_pin_three_out;
  wire pe_di = serial_master ? port_b_pin_three_in : port_b_pin_two_in;
  int err_count = 0;
  int checks_done = 0;
  logic [7:0] sent[$], got[$], pq[$], rxq[$];
  port_b_spi_data_pin_mux u_dut (.*);
  ser_peer_model u_peer (.ser_clk(ser_clk), .link_frame(link_frame), .sdo(pe_do), .sdo_oe(pe_oe), .sdi(pe_di));
  always #25 clk = ~clk;
  always @(posedge clk) if ((rx_valid && rx_ready) === 1'b1) rxq.push_back(rx_data);
  function automatic logic lvl(input logic d, input logic o, input logic b);
    return d ? o : b;
  endfunction : lvl
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic xfer(input logic m);
    serial_master = m;
    u_peer.frame(8'h00, w);
    tick(8);
    sent = {};
    got = {};
    pq = {};
    rxq = {};
    for (int i = 0; i < 4 && tx_ready === 1'b1; i++) begin
      tx_data = 8'($urandom_range(8'hfd));
      tx_valid = 1'b1;
      tick(1);
      sent.push_back(tx_data);
    end
    tx_data = 8'hfe;
    tick(2);
    tx_valid = 1'b0;
    check({7'h0, tx_ready}, 8'h00);
    for (int k = 0; k < 10; k++) begin
      pq.push_back(8'($urandom));
      u_peer.frame(pq[k], w);
      if (w !== IDLE_WORD) got.push_back(w);
      tick(8);
    end
    check(8'(got.size()), 8'(sent.size()));
    foreach (sent[i]) check(got[i], sent[i]);
    foreach (pq[i]) check(rxq[i], pq[i]);
    check({6'h0, port_b_pin_three_oe, port_b_pin_two_oe}, {6'h0, m, 1'b0});
    $display("test serial done, master %0d", m);
  endtask : xfer
  // Whole run is some tens of microseconds; this leaves wide margin.
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'hfcde));
    fork
      u_peer.spin(7);
      tick(5);
    join
    check({4'h0, port_b_pin_two_oe, port_b_pin_three_oe, port_b_pin_two_pullup, port_b_pin_three_pullup}, 8'h03);
    reset = 1'b0;
    tick(4);
    check({4'h0, port_b_pin_two_oe, port_b_pin_three_oe, timer_a_chan_two_here, timer_a_chan_three_here}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      gpio_dir = 2'($urandom);
      gpio_out = 2'($urandom);
      bv = 2'($urandom);
      bo = ~gpio_dir;
      tick(5);
      for (int b = 0; b < 2; b++) check({7'h0, gpio_in[b]}, {7'h0, lvl(gpio_dir[b], gpio_out[b], bv[b])});
      check({6'h0, port_b_pin_three_oe, port_b_pin_two_oe}, {6'h0, gpio_dir});
    end
    $display("test gpio done");
    for (int i = 0; i < 8; i++) begin
      fsel_two = i[0] ? FSEL_PWM_SRC : FSEL_TIMER;
      fsel_three = fsel_two;
      toe = 2'($urandom);
      tout = 2'($urandom);
      bv = 2'($urandom);
      bo = i[0] ? 2'h3 : ~toe;
      tick(7);
      if (i[0]) begin
        check({6'h0, ext_pwm_source_one, ext_pwm_source_zero}, {6'h0, bv});
      end else begin
        check({6'h0, timer_a_chan_three_here, timer_a_chan_two_here}, 8'h03);
        check({6'h0, port_b_pin_three_oe, port_b_pin_two_oe}, {6'h0, toe});
        for (int b = 0; b < 2; b++) check({7'h0, b[0] ? timer_a_chan_three_in : timer_a_chan_two_in},
          {7'h0, lvl(toe[b], tout[b], bv[b])});
      end
    end
    fsel_two = FSEL_GPIO;
    fsel_three = FSEL_GPIO;
    tick(4);
    check({4'h0, timer_a_chan_three_here, timer_a_chan_two_here, ext_pwm_source_one, ext_pwm_source_zero}, 8'h00);
    $display("test timer and source done");
    fsel_two = FSEL_SERIAL;
    fsel_three = FSEL_SERIAL;
    bo = 2'h0;
    xfer(1'b1);
    rx_ready = 1'b0;
    u_peer.frame(8'h3c, w);
    u_peer.frame(8'hc3, w);
    tick(8);
    check({7'h0, rx_overrun}, 8'h01);
    check(rx_data, 8'hc3);
    rx_ready = 1'b1;
    tick(2);
    $display("test overrun done");
    xfer(1'b0);
    test_done();
  end
endmodule : port_b_spi_data_pin_mux_tb
